// ---- rtl/cocr_pkg.sv ----
/*
 * Constants shared by the clock output control register bank: bus
 * addresses, byte indexes, field positions and power-up values.
 * Assumes nothing of its surroundings; imported by every design file except cocr_stop_gate.
 */
package cocr_pkg;

    // Register bank index width and bus addresses of the serial port
    localparam int          IDX_W     = 4;
    localparam logic [7:0]  WR_ADDR   = 8'hd2;
    localparam logic [7:0]  RD_ADDR   = 8'hd3;

    // Byte indexes
    localparam logic [IDX_W-1:0] IDX_BUS_CLK  = 4'h2;
    localparam logic [IDX_W-1:0] IDX_FREE_48  = 4'h3;
    localparam logic [IDX_W-1:0] IDX_MID_GRP  = 4'h4;
    localparam logic [IDX_W-1:0] IDX_SPREAD   = 4'h5;
    localparam logic [IDX_W-1:0] IDX_SIGN     = 4'h6;
    localparam logic [IDX_W-1:0] IDX_RSVD     = 4'h7;
    localparam logic [IDX_W-1:0] IDX_FB_DIV   = 4'h8;
    localparam logic [IDX_W-1:0] IDX_REF_DIV  = 4'h9;

    // Power-up values
    localparam logic [7:0] RST_BUS_CLK = 8'h7f;
    localparam logic [7:0] RST_FREE_48 = 8'hc7;
    localparam logic [7:0] RST_MID_GRP = 8'h3f;
    localparam logic [7:0] RST_SPREAD  = 8'h40;
    localparam logic [7:0] RST_FB_DIV  = 8'h00;
    localparam logic [7:0] RST_REF_DIV = 8'h00;
    localparam logic [7:0] RSVD_VALUE  = 8'h00;

    // Bit 7 of both divider bytes is reserved and always reads zero
    localparam logic [7:0] DIV_MASK    = 8'h7f;

    // Field positions
    localparam int REF_STRENGTH_BIT = 7;
    localparam int DISP48_EN_BIT    = 7;
    localparam int SER48_EN_BIT     = 6;
    localparam int FREE_STOP_LSB    = 3;
    localparam int SPREAD_HI_BIT    = 7;
    localparam int SPREAD_MID_BIT   = 7;
    localparam int SPREAD_LO_BIT    = 6;
    localparam int DELAY_LSB        = 4;
    localparam int DISP_SLOW_BIT    = 2;
    localparam int SER_SLOW_BIT     = 0;
    localparam int REF_DIV_LSB      = 1;
    localparam int DIV_SEL_BIT      = 0;

endpackage

// ---- rtl/cocr_regs.sv ----
/*
 * Control register bank, bytes 2 to 9, of a multi-output clock
 * synthesizer. Assumes an external serial framing engine that hands over
 * each data byte with the bus address byte and the running byte index,
 * synchronous to core_clk; the command and count bytes are absorbed there.
 */
// Contract
// RULE1: Byte 2 bit 7 picks reference drive, 0 high, 1 low; resets 0.
// RULE2: Byte 2 bits 6..0 enable seven bus clocks; resets all ones.
// RULE3: Byte 3 bits 7,6 enable display and serial-bus 48 MHz clocks.
// RULE4: Byte 3 bits 5..3 make free bus clocks stop on stop-low.
// RULE5: Byte 3 bits 2..0 enable free bus clocks 2..0; reset ones.
// RULE6: Byte 4 bit 7 is top spread bit, 0 down, 1 center.
// RULE7: Byte 4 bits 5..0 enable six mid-rate group outputs; reset ones.
// RULE8: Byte 5 bits 7,6 are middle and low spread bits, reset 0,1.
// RULE9: Byte 5 bits 5,4 form the buffered clock delay code.
// RULE10: Byte 5 bit 2 slows display clock edges by 15 percent.
// RULE11: Byte 5 bit 0 slows serial-bus clock edges by 15 percent.
// RULE12: Bytes 2 to 5 read back whatever was last written.
// RULE13: Byte 7 and other reserved bits hold zero; host writes zero.
// RULE14: Byte 6 reads fixed revision and vendor codes, read-only.
// RULE15: Byte 8 bits 6..0 hold feedback divider value, reset zero.
// RULE16: Byte 9 bits 6..1 hold reference divider value, reset zero.
// RULE17: Byte 9 bit 0 picks table dividers (0) or programmed (1).
// RULE18: Divider change keeps every derived clock ratio to CPU clock.
// RULE19: Writes only at address d2, reads only at d3, others ignored.
// RULE20: Host sends command and count bytes first; their content ignored.
// RULE21: Writes to the signature byte are acknowledged and discarded.
// RULE22: Reset loads every documented default onto the control outputs. Code holds free_bus_clock_run low during reset instead.
`timescale 1ns/1ps

module cocr_regs
    import cocr_pkg::*;
#(
    parameter logic [3:0] REV_CODE    = 4'h5,  // Arbitrary value
    parameter logic [3:0] VENDOR_CODE = 4'ha   // Arbitrary value
) (
    input  wire logic             core_clk,
    input  wire logic             rstn,
    input  wire logic [7:0]       bus_addr,
    input  wire logic [IDX_W-1:0] reg_index,
    input  wire logic             wr_stb,
    input  wire logic [7:0]       wr_data,
    input  wire logic             rd_stb,
    output logic      [7:0]       rd_data,
    output logic                  rd_valid,
    output logic                  ack,
    input  wire logic             bus_clock_stop_n,
    input  wire logic [6:0]       table_fb_div,
    input  wire logic [5:0]       table_ref_div,
    output logic                  ref_low_strength,
    output logic      [6:0]       bus_clock_en,
    output logic                  display_clock_48_en,
    output logic                  serial_bus_clock_48_en,
    output logic      [2:0]       free_bus_clock_run,
    output logic      [5:0]       mid_rate_clock_en,
    output logic                  spread_select_hi,
    output logic                  spread_select_mid,
    output logic                  spread_select_lo,
    output logic      [1:0]       buffer_delay_code,
    output logic                  display_clock_48_slow,
    output logic                  serial_bus_clock_48_slow,
    output logic                  divider_source_select,
    output logic      [6:0]       pll_fb_div,
    output logic      [5:0]       pll_ref_div
);

    typedef struct packed {
        logic [7:0] bus_clock_control;
        logic [7:0] free_bus_and_48m_control;
        logic [7:0] mid_clock_group_control;
        logic [7:0] spread_delay_edge_control;
        logic [7:0] feedback_divider_value;
        logic [7:0] reference_divider_and_select;
        logic [7:0] rd_data;
        logic       rd_valid;
        logic       ack;
    } cocr_state_t;

    cocr_state_t state;
    cocr_state_t next_state;
    logic        idx_in_bank;
    logic        wr_hit;
    logic        rd_hit;
    logic [7:0]  read_byte;

    ////////////////////////////////////////////////////////////////////
    // Address decode; bytes 0 and 1 live elsewhere and get no answer
    assign idx_in_bank = (reg_index >= IDX_BUS_CLK) &&
                         (reg_index <= IDX_REF_DIV);
    assign wr_hit = wr_stb && (bus_addr == WR_ADDR) && idx_in_bank; // RULE19
    assign rd_hit = rd_stb && (bus_addr == RD_ADDR) && idx_in_bank; // RULE19

    ////////////////////////////////////////////////////////////////////
    // Read multiplexer
    always_comb begin
        case (reg_index)
            IDX_BUS_CLK: read_byte = state.bus_clock_control; // RULE12
            IDX_FREE_48: read_byte = state.free_bus_and_48m_control;
            IDX_MID_GRP: read_byte = state.mid_clock_group_control;
            IDX_SPREAD:  read_byte = state.spread_delay_edge_control;
            IDX_SIGN:    read_byte = {REV_CODE, VENDOR_CODE}; // RULE14
            IDX_RSVD:    read_byte = RSVD_VALUE; // RULE13
            IDX_FB_DIV:  read_byte = state.feedback_divider_value;
            IDX_REF_DIV: read_byte = state.reference_divider_and_select;
            default:     read_byte = 8'h00;
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // Next state: writes, read capture, then reset on top of all
    always_comb begin
        next_state = state;
        next_state.rd_valid = 1'b0;
        next_state.ack = wr_hit || rd_hit;
        if (wr_hit) begin
            case (reg_index)
                IDX_BUS_CLK: begin
                    next_state.bus_clock_control = wr_data; // RULE12
                end
                IDX_FREE_48: begin
                    next_state.free_bus_and_48m_control = wr_data;
                end
                IDX_MID_GRP: begin
                    next_state.mid_clock_group_control = wr_data;
                end
                IDX_SPREAD: begin
                    next_state.spread_delay_edge_control = wr_data;
                end
                IDX_FB_DIV: begin
                    // Reserved top bit is dropped so it always reads zero
                    next_state.feedback_divider_value =
                        wr_data & DIV_MASK; // RULE15 RULE13
                end
                IDX_REF_DIV: begin
                    next_state.reference_divider_and_select =
                        wr_data & DIV_MASK; // RULE16 RULE17 RULE13
                end
                default: begin
                    // Signature and reserved bytes: acknowledged, discarded
                end // RULE21 RULE13
            endcase
        end
        // Both strobes at once: bus_addr lets only one of them hit, never both
        if (rd_hit) begin
            next_state.rd_valid = 1'b1;
            next_state.rd_data  = read_byte;
        end
        if (!rstn) begin
            next_state.bus_clock_control            = RST_BUS_CLK; // RULE22
            next_state.free_bus_and_48m_control     = RST_FREE_48;
            next_state.mid_clock_group_control      = RST_MID_GRP;
            next_state.spread_delay_edge_control    = RST_SPREAD;
            next_state.feedback_divider_value       = RST_FB_DIV;
            next_state.reference_divider_and_select = RST_REF_DIV;
            next_state.rd_data  = 8'h00;
            next_state.rd_valid = 1'b0;
            next_state.ack      = 1'b0;
        end
    end

    // Register the whole state; reset is folded into the next value
    always_ff @(posedge core_clk) begin
        state <= next_state;
    end

    ////////////////////////////////////////////////////////////////////
    // Control outputs straight from the register bytes
    assign rd_data  = state.rd_data;
    assign rd_valid = state.rd_valid;
    assign ack      = state.ack;
    assign ref_low_strength =
        state.bus_clock_control[REF_STRENGTH_BIT]; // RULE1
    assign bus_clock_en = state.bus_clock_control[6:0]; // RULE2
    assign display_clock_48_en =
        state.free_bus_and_48m_control[DISP48_EN_BIT]; // RULE3
    assign serial_bus_clock_48_en =
        state.free_bus_and_48m_control[SER48_EN_BIT]; // RULE3
    assign mid_rate_clock_en = state.mid_clock_group_control[5:0]; // RULE7
    assign spread_select_hi =
        state.mid_clock_group_control[SPREAD_HI_BIT]; // RULE6
    assign spread_select_mid =
        state.spread_delay_edge_control[SPREAD_MID_BIT]; // RULE8
    assign spread_select_lo =
        state.spread_delay_edge_control[SPREAD_LO_BIT]; // RULE8
    assign buffer_delay_code =
        state.spread_delay_edge_control[DELAY_LSB+:2]; // RULE9
    assign display_clock_48_slow =
        state.spread_delay_edge_control[DISP_SLOW_BIT]; // RULE10
    assign serial_bus_clock_48_slow =
        state.spread_delay_edge_control[SER_SLOW_BIT]; // RULE11
    assign divider_source_select =
        state.reference_divider_and_select[DIV_SEL_BIT]; // RULE17

    ////////////////////////////////////////////////////////////////////
    // One divider pair feeds the single PLL, so every derived clock
    // keeps its ratio to the CPU clock whichever source is chosen
    assign pll_fb_div = divider_source_select ?
        state.feedback_divider_value[6:0] : table_fb_div; // RULE17 RULE18
    assign pll_ref_div = divider_source_select ?
        state.reference_divider_and_select[REF_DIV_LSB+:6] :
        table_ref_div; // RULE17 RULE18

    ////////////////////////////////////////////////////////////////////
    // Free-running clocks with stop participation
    cocr_stop_gate #(
        .WIDTH (3)
    ) u_free_gate (
        .core_clk         (core_clk),
        .rstn             (rstn),
        .enable           (state.free_bus_and_48m_control[2:0]),
        .stop_part        (state.free_bus_and_48m_control[FREE_STOP_LSB+:3]),
        .bus_clock_stop_n (bus_clock_stop_n),
        .run              (free_bus_clock_run)
    ); // RULE4 RULE5

    ////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);

    a_reset_defaults: assert property (disable iff (1'b0) // RULE22
        !rstn |=> (bus_clock_en == 7'h7f && !ref_low_strength &&
                   mid_rate_clock_en == 6'h3f && spread_select_lo &&
                   !spread_select_mid && !divider_source_select))
        else $error("power-up defaults not loaded");
    a_bus_clk_write: assert property ( // RULE2
        (rstn && wr_hit && reg_index == IDX_BUS_CLK) |=>
        (bus_clock_en == $past(wr_data[6:0]) &&
         ref_low_strength == $past(wr_data[7])))
        else $error("bus clock byte write not applied");
    a_48m_enables: assert property ( // RULE3
        (rstn && wr_hit && reg_index == IDX_FREE_48) |=>
        ({display_clock_48_en, serial_bus_clock_48_en} ==
         $past(wr_data[7:6])))
        else $error("48 MHz enables not applied");
    a_mid_spread_hi: assert property ( // RULE7
        (rstn && wr_hit && reg_index == IDX_MID_GRP) |=>
        (mid_rate_clock_en == $past(wr_data[5:0]) &&
         spread_select_hi == $past(wr_data[7])))
        else $error("mid group byte not applied");
    a_spread_edge: assert property ( // RULE8
        (rstn && wr_hit && reg_index == IDX_SPREAD) |=>
        ({spread_select_mid, spread_select_lo, buffer_delay_code,
          display_clock_48_slow, serial_bus_clock_48_slow} ==
         {$past(wr_data[7:4]), $past(wr_data[2]), $past(wr_data[0])}))
        else $error("spread and edge byte not applied");
    a_readback_same: assert property ( // RULE12
        (rstn && wr_hit && reg_index <= IDX_SPREAD) ##1
        (rstn && rd_hit && !wr_hit && reg_index == $past(reg_index)) |=>
        (rd_valid && rd_data == $past(wr_data, 2)))
        else $error("read back differs from last write");
    a_rsvd_reads: assert property ( // RULE13
        (rstn && rd_hit && reg_index == IDX_RSVD) |=>
        (rd_valid && rd_data == 8'h00))
        else $error("reserved byte read non-zero");
    a_sign_read: assert property ( // RULE14
        (rstn && rd_hit && reg_index == IDX_SIGN) |=>
        (rd_valid && rd_data == {REV_CODE, VENDOR_CODE}))
        else $error("signature read wrong");
    a_sign_write: assert property ( // RULE21
        (rstn && wr_hit && reg_index == IDX_SIGN) |=>
        (ack && $stable(state.bus_clock_control) &&
         $stable(state.reference_divider_and_select)))
        else $error("signature write not acked or leaked");
    a_div_source: assert property ( // RULE17
        (rstn && wr_hit && reg_index == IDX_REF_DIV && wr_data[0]) |=>
        (divider_source_select &&
         pll_ref_div == $past(wr_data[6:1]) &&
         pll_fb_div == state.feedback_divider_value[6:0]))
        else $error("programmed dividers not selected");
    a_foreign_addr: assert property ( // RULE19
        (rstn && wr_stb && !rd_stb && bus_addr != WR_ADDR) |=>
        (!ack && $stable(state.bus_clock_control) &&
         $stable(state.spread_delay_edge_control)))
        else $error("write at foreign address took effect");

    // Divider bytes, refused bytes and held read data
    a_fb_div_write: assert property ( // RULE15
        (rstn && wr_hit && reg_index == IDX_FB_DIV) |=>
        (state.feedback_divider_value == {1'b0, $past(wr_data[6:0])}))
        else $error("feedback divider byte not stored");
    a_ref_div_write: assert property ( // RULE16
        (rstn && wr_hit && reg_index == IDX_REF_DIV) |=>
        (state.reference_divider_and_select ==
         {1'b0, $past(wr_data[6:0])}))
        else $error("reference divider byte not stored");
    a_table_source: assert property ( // RULE17
        (rstn && wr_hit && reg_index == IDX_REF_DIV && !wr_data[0]) |=>
        (!divider_source_select && pll_fb_div == table_fb_div &&
         pll_ref_div == table_ref_div))
        else $error("table dividers not selected");
    a_rd_data_holds: assert property ( // RULE19
        !rd_hit |=> $stable(rd_data))
        else $error("read data changed without a read");
    a_outside_bank: assert property ( // RULE19
        ((wr_stb || rd_stb) &&
         (reg_index < IDX_BUS_CLK || reg_index > IDX_REF_DIV)) |=> !ack)
        else $error("byte outside the bank answered");
    a_write_ack: assert property ( // RULE21
        (wr_stb && bus_addr == WR_ADDR && reg_index >= IDX_BUS_CLK &&
         reg_index <= IDX_REF_DIV) |=> ack)
        else $error("in-bank write not acknowledged");

    c_write_read: cover property (wr_hit ##1 rd_hit ##1 rd_valid);
    c_sign_read: cover property (rd_hit && reg_index == IDX_SIGN);
    c_div_program: cover property (
        wr_hit && reg_index == IDX_REF_DIV && wr_data[0]);
    c_stop_free: cover property (
        !bus_clock_stop_n && state.free_bus_and_48m_control[5]);
    c_table_source: cover property (
        wr_hit && reg_index == IDX_REF_DIV && !wr_data[0]);

endmodule

// ---- rtl/cocr_stop_gate.sv ----
/*
 * Run control for a group of free-running bus clocks: a clock runs when
 * enabled, unless it takes part in the stop function and the stop input
 * is low. Assumes the stop input is already synchronous to core_clk.
 */
`timescale 1ns/1ps

module cocr_stop_gate #(
    parameter int WIDTH = 3
) (
    input  wire logic             core_clk,
    input  wire logic             rstn,
    input  wire logic [WIDTH-1:0] enable,
    input  wire logic [WIDTH-1:0] stop_part,
    input  wire logic             bus_clock_stop_n,
    output logic      [WIDTH-1:0] run
);

    typedef struct packed {
        logic [WIDTH-1:0] run;
    } cocr_gate_t;

    cocr_gate_t state;
    cocr_gate_t next_state;

    ////////////////////////////////////////////////////////////////////
    // Next run level; reset leaves every output held low
    always_comb begin
        next_state = state;
        next_state.run = enable &
            ~(stop_part & {WIDTH{~bus_clock_stop_n}}); // RULE4 RULE5
        if (!rstn) begin
            next_state.run = '0;
        end
    end

    always_ff @(posedge core_clk) begin
        state <= next_state;
    end

    assign run = state.run;

    ////////////////////////////////////////////////////////////////////
    // Checks
    a_stop_holds: assert property ( // RULE4
        @(posedge core_clk) disable iff (!rstn)
        (!bus_clock_stop_n && rstn) |=> ((run & $past(stop_part)) == '0))
        else $error("stoppable clock ran while stop was low");
    a_disable_holds: assert property ( // RULE5
        @(posedge core_clk) disable iff (!rstn)
        rstn |=> ((run & ~$past(enable)) == '0))
        else $error("disabled clock output ran");

endmodule

// ---- verification/clock_output_control_regs_bench.sv ----
/*
 * Self-checking bench for the clock output control register bank.
 * Assumes the host model drives the register port; the bench drives the
 * stop input and the table divider values itself.
 */
`timescale 1ns/1ps

module clock_output_control_regs_bench;
    import cocr_pkg::*;

    localparam logic [3:0] REV = 4'h6;  // Arbitrary value
    localparam logic [3:0] VEN = 4'h9;  // Arbitrary value

    logic             core_clk, rstn, bus_clock_stop_n;
    logic [6:0]       table_fb_div, pll_fb_div, bus_clock_en;
    logic [5:0]       table_ref_div, pll_ref_div, mid_rate_clock_en;
    logic [7:0]       bus_addr, wr_data, rd_data, d, last_rd;
    logic [IDX_W-1:0] reg_index;
    logic             wr_stb, rd_stb, rd_valid, ack, a, v;
    logic             ref_low_strength, display_clock_48_en;
    logic             serial_bus_clock_48_en, spread_select_hi;
    logic             spread_select_mid, spread_select_lo;
    logic             display_clock_48_slow, serial_bus_clock_48_slow;
    logic             divider_source_select;
    logic [2:0]       free_bus_clock_run;
    logic [1:0]       buffer_delay_code;
    logic [7:0]       sh [2:9];
    logic [7:0]       pat [3] = '{8'h00, 8'hff, 8'ha5};
    int               miscompares = 0;
    int               tests_run = 0;

    cocr_regs #(.REV_CODE(REV), .VENDOR_CODE(VEN)) dut (
        .core_clk, .rstn, .bus_addr, .reg_index, .wr_stb, .wr_data,
        .rd_stb, .rd_data, .rd_valid, .ack, .bus_clock_stop_n,
        .table_fb_div, .table_ref_div, .ref_low_strength, .bus_clock_en,
        .display_clock_48_en, .serial_bus_clock_48_en, .free_bus_clock_run,
        .mid_rate_clock_en, .spread_select_hi, .spread_select_mid,
        .spread_select_lo, .buffer_delay_code, .display_clock_48_slow,
        .serial_bus_clock_48_slow, .divider_source_select, .pll_fb_div,
        .pll_ref_div);

    cocr_host_model host (
        .core_clk, .bus_addr, .reg_index, .wr_stb, .wr_data, .rd_stb,
        .rd_data, .rd_valid, .ack);

    ////////////////////////////////////////////////////////////////////////
    // Clock, 8 ns period
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // Signature and reserved byte never follow the shadow
    function automatic logic [7:0] exp_byte(input int i);
        if (i == 6) return {REV, VEN};
        if (i == 7) return 8'h00;
        return sh[i];
    endfunction

    // Shadow copy of the power-up contents
    task automatic load_defaults();
        sh[2] = 8'h7f;
        sh[3] = 8'hc7;
        sh[4] = 8'h3f;
        sh[5] = 8'h40;
        sh[8] = 8'h00;
        sh[9] = 8'h00;
    endtask

    // One more edge so the registered stop gating has landed too
    task automatic chk_outs();
        @(posedge core_clk);
        #1;
        chk(8'(ref_low_strength), 8'(sh[2][7]));
        chk(8'(bus_clock_en), 8'(sh[2][6:0]));
        chk(8'({display_clock_48_en, serial_bus_clock_48_en}),
            8'(sh[3][7:6]));
        chk(8'(free_bus_clock_run), 8'(sh[3][2:0] &
            ~(sh[3][5:3] & {3{~bus_clock_stop_n}})));
        chk(8'(spread_select_hi), 8'(sh[4][7]));
        chk(8'(mid_rate_clock_en), 8'(sh[4][5:0]));
        chk(8'({spread_select_mid, spread_select_lo}), 8'(sh[5][7:6]));
        chk(8'(buffer_delay_code), 8'(sh[5][5:4]));
        chk(8'(display_clock_48_slow), 8'(sh[5][2]));
        chk(8'(serial_bus_clock_48_slow), 8'(sh[5][0]));
        chk(8'(divider_source_select), 8'(sh[9][0]));
        chk(8'(pll_fb_div),
            8'(sh[9][0] ? sh[8][6:0] : table_fb_div));
        chk(8'(pll_ref_div),
            8'(sh[9][0] ? sh[9][6:1] : table_ref_div));
    endtask

    task automatic rd(input logic [IDX_W-1:0] i, input logic [7:0] exp);
        host.xfer(RD_ADDR, i, 1'b1, 8'h00, a, v, d);
        chk(8'(a), 8'h01);
        chk(8'(v), 8'h01);
        chk(d, exp);
        last_rd = d;
    endtask

    task automatic wr(input logic [IDX_W-1:0] i, input logic [7:0] raw);
        logic [7:0] val;
        // Host keeps every reserved bit at zero
        val = raw & (i == 7 ? 8'h00 : i == 4 ? 8'hbf : i == 5 ? 8'hf5 :
                     i > 7 ? 8'h7f : 8'hff);
        host.xfer(WR_ADDR, i, 1'b0, val, a, v, d);
        chk(8'(a), 8'h01);
        if (i inside {[2:5], [8:9]}) sh[i] = val;
        chk_outs();
    endtask

    // Refused byte: no answer and the read buffer keeps its last value
    task automatic nak(input logic [7:0] ad, input logic [IDX_W-1:0] i,
                       input logic r);
        host.xfer(ad, i, r, 8'h3c, a, v, d);
        chk(8'(a), 8'h00);
        chk(8'(v), 8'h00);
        chk(d, last_rd);
    endtask

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Whole run is a few hundred cycles; this leaves ample margin
    initial begin
        #100000;
        miscompares++;
        tally_and_finish();
    end

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        rstn = 1'b0;
        bus_clock_stop_n = 1'b1;
        table_fb_div = 7'h55;
        table_ref_div = 6'h2a;
        load_defaults();
        repeat (6) @(posedge core_clk);
        #1;
        rstn = 1'b1;
        chk_outs();
        for (int i = 2; i <= 9; i++) rd(4'(i), exp_byte(i));
        $display("reset values done");
        // Signature byte gets written on purpose, with nonzero data in two of the three patterns
        foreach (pat[p]) begin
            host.gap = p;
            for (int i = 2; i <= 9; i++) wr(4'(i), pat[p]);
            for (int i = 2; i <= 9; i++) rd(4'(i), exp_byte(i));
        end
        // Write then read the same byte on consecutive edges
        foreach (pat[p]) begin
            host.wr_rd(4'h2, pat[p], a, v, d);
            sh[2] = pat[p];
            last_rd = d;
            chk(8'({a, v}), 8'h03);
            chk(d, sh[2]);
        end
        $display("write and read back done");
        wr(4'h3, 8'h2f);
        #1;
        bus_clock_stop_n = 1'b0;
        chk_outs();
        bus_clock_stop_n = 1'b1;
        chk_outs();
        $display("stop participation done");
        nak(RD_ADDR, 4'h2, 1'b0);
        nak(WR_ADDR, 4'h2, 1'b1);
        nak(8'h00, 4'h3, 1'b0);
        for (int k = 0; k < 2; k++) nak(WR_ADDR, 4'(k), 1'b0);
        nak(RD_ADDR, 4'h1, 1'b1);
        nak(WR_ADDR, 4'ha, 1'b0);
        nak(RD_ADDR, 4'hf, 1'b1);
        for (int i = 2; i <= 9; i++) rd(4'(i), exp_byte(i));
        $display("refused accesses done");
        // Mid-run reset brings every byte back to its power-up value
        rstn = 1'b0;
        repeat (2) @(posedge core_clk);
        #1;
        rstn = 1'b1;
        load_defaults();
        chk_outs();
        for (int i = 2; i <= 9; i++) rd(4'(i), exp_byte(i));
        $display("mid-run reset done");
        tally_and_finish();
    end
endmodule

// ---- verification/cocr_host_model.sv ----
/*
 * Host-side model of the serial framing engine feeding the register bank:
 * one strobe per data byte, with address and byte index alongside.
 * Assumes the bench calls xfer from one process, on core_clk time.
 */
`timescale 1ns/1ps

module cocr_host_model
    import cocr_pkg::*;
(
    input  wire logic             core_clk,
    output logic      [7:0]       bus_addr,
    output logic      [IDX_W-1:0] reg_index,
    output logic                  wr_stb,
    output logic      [7:0]       wr_data,
    output logic                  rd_stb,
    input  wire logic [7:0]       rd_data,
    input  wire logic             rd_valid,
    input  wire logic             ack
);
    // Idle cycles before each xfer byte (wr_rd skips them), so the bench can run slow hosts
    int gap = 0;

    initial begin
        bus_addr  = 8'h00;
        reg_index = 4'h0;
        wr_stb    = 1'b0;
        wr_data   = 8'h00;
        rd_stb    = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // Command and count bytes are absorbed by the framing engine, so only
    // data bytes reach the bank; the address rides along with each byte
    task automatic xfer(input logic [7:0] addr, input logic [IDX_W-1:0] idx,
                        input logic rd, input logic [7:0] data,
                        output logic got_ack, output logic got_valid,
                        output logic [7:0] got_data);
        repeat (gap) @(posedge core_clk);
        @(posedge core_clk);
        #1;
        bus_addr  = addr;
        reg_index = idx;
        wr_data   = data;
        wr_stb    = ~rd;
        rd_stb    = rd;
        @(posedge core_clk);
        #1;
        got_ack   = ack;
        got_valid = rd_valid;
        got_data  = rd_data;
        wr_stb    = 1'b0;
        rd_stb    = 1'b0;
        // Released lines carry garbage, not the last value
        bus_addr  = ~addr;
        reg_index = ~idx;
        wr_data   = ~data;
    endtask

    // Write then read one byte on consecutive edges; strobes swap at once
    task automatic wr_rd(input logic [IDX_W-1:0] idx, input logic [7:0] data,
                         output logic got_ack, output logic got_valid,
                         output logic [7:0] got_data);
        @(posedge core_clk);
        #1;
        bus_addr  = WR_ADDR;
        reg_index = idx;
        wr_data   = data;
        wr_stb    = 1'b1;
        @(posedge core_clk);
        #1;
        got_ack   = ack;
        bus_addr  = RD_ADDR;
        wr_stb    = 1'b0;
        rd_stb    = 1'b1;
        @(posedge core_clk);
        #1;
        got_ack   = got_ack & ack;
        got_valid = rd_valid;
        got_data  = rd_data;
        rd_stb    = 1'b0;
        bus_addr  = ~RD_ADDR;
        reg_index = ~idx;
        wr_data   = ~data;
    endtask
endmodule
